// >>> ccs_battery_model.sv
/*
  battery stack and power stage model for the sequencer bench.
  assumes straps, faults, thermistor and die temp are set by the bench.
*/
`timescale 1ns/1ps
module ccs_battery_model (
  input  wire logic                pclk,    // system clock
  input  wire logic                presetn, // reset, active low
  input  wire ccs_pkg::ccs_drive_s drive,   // power stage controls
  input  wire logic [3:0]          strap,   // hi and lo strap levels
  input  wire logic [2:0]          flt,     // open, short, unstable
  input  wire logic                topen,   // open thermistor
  input  wire logic [7:0]          temp,    // die temp, deg C
  output ccs_pkg::ccs_sense_s      sense    // comparator bundle
);
  import ccs_pkg::*;
  logic [7:0] v_r; // stack voltage, arbitrary steps
  // stack only rises while a current path is on, so phases advance in order
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      v_r <= 8'h00;
    else if ((drive.trickle_en || drive.switcher_en) && v_r != 8'hff)
      v_r <= v_r + 8'h01;
  assign sense = {strap, flt[0], flt[2], flt[1], v_r < 8'h14, v_r < 8'hc8, topen, temp};
endmodule : ccs_battery_model

// >>> ccs_pkg.sv
/*
  Shared constants and types for the charge cycle sequencer: register map,
  reset values, strap level codes, state encoding, timing counts and the
  packed carriers for the analog sense and drive bundles.
  Assumes a 40 MHz system clock and an APB master with 32-bit data.
*/
package ccs_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_PS   = 25000;
  localparam int CYC_PER_US      = 1_000_000 / CLK_PERIOD_PS;
  localparam int RAMP_STEP_US    = 400;
  localparam int TICK_CYC        = RAMP_STEP_US * CYC_PER_US;
  localparam int DETECT_HALF_MS  = 1500;   // two halves give a 3 s presence test
  localparam int OPEN_SHORT_MS   = 1500;
  localparam int RETRY_S         = 30;
  localparam int PROFILE_US      = 11000;
  localparam int DETECT_TICKS    = DETECT_HALF_MS * 1000 / RAMP_STEP_US;
  localparam int OPEN_SHORT_TICKS = OPEN_SHORT_MS * 1000 / RAMP_STEP_US;
  localparam int RETRY_TICKS     = RETRY_S * 1_000_000 / RAMP_STEP_US;
  localparam int PROFILE_CYC     = PROFILE_US * CYC_PER_US;

  // ----------------------------------------------------------------------
  // codes and levels
  // ----------------------------------------------------------------------
  localparam logic [1:0]  LV_GND       = 2'h0;
  localparam logic [1:0]  LV_MID       = 2'h1;   // mid_supply_level
  localparam logic [1:0]  LV_HIGH      = 2'h2;
  localparam logic [4:0]  CODE_MAX     = 5'h1f;
  localparam logic [4:0]  CODE_PRECH   = 5'h03;
  localparam logic [8:0]  VREG_BASE    = 9'h131; // 3.8125 V in 12.5 mV steps

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0]  ADR_CTRL     = 8'h00;
  localparam logic [7:0]  ADR_USER     = 8'h04;
  localparam logic [7:0]  ADR_THERM    = 8'h08;
  localparam logic [7:0]  ADR_ALERT_EN = 8'h0c;
  localparam logic [7:0]  ADR_ALERT    = 8'h10;
  localparam logic [7:0]  ADR_STATUS   = 8'h14;
  localparam logic [7:0]  ADR_DAC      = 8'h18;
  localparam logic [4:0]  RST_ICODE    = 5'h1f;
  localparam logic [4:0]  RST_VCODE    = 5'h1f;
  localparam logic [7:0]  RST_T_START  = 8'h78;  // 120 C
  localparam logic [7:0]  RST_T_END    = 8'h7d;  // 125 C
  localparam int          AL_MISSING   = 0;
  localparam int          AL_SHORT     = 1;
  localparam int          AL_DETFAIL   = 2;
  localparam int          AL_THERMAL   = 3;

  typedef enum logic [9:0] {
    ST_CFG_ERR  = 10'h001,
    ST_DET_LOAD = 10'h002,
    ST_DET_CHG  = 10'h004,
    ST_OPEN_SHT = 10'h008,
    ST_MISSING  = 10'h010,
    ST_SHORTED  = 10'h020,
    ST_DET_FAIL = 10'h040,
    ST_TRICKLE  = 10'h080,
    ST_PRECHG   = 10'h100,
    ST_MAIN     = 10'h200
  } ccs_state_e;

  typedef struct packed {
    logic [1:0] count_strap_hi;
    logic [1:0] count_strap_lo;
    logic       bat_unstable;   // battery voltage moving during the test
    logic       bat_open;
    logic       bat_short;
    logic       sense_low;      // battery_sense_pin below 2.5 V
    logic       sense_prech;    // below 2.85 V per cell
    logic       therm_open;
    logic [7:0] die_temp;       // degrees C
  } ccs_sense_s;

  typedef struct packed {
    logic       det_load_en;
    logic       det_chg_en;
    logic       trickle_en;
    logic       switcher_en;
    logic [4:0] icharge_dac;
    logic [4:0] vcharge_dac;
  } ccs_drive_s;

endpackage : ccs_pkg

// >>> ccs_sequencer.sv
/*
  Charge cycle sequencer: strap decode, battery detection with faults and
  retry, ramped current DAC, trickle/precharge/main phases, thermal cap,
  APB register file and the active-low alert line.
  Assumes analog comparators deliver the sense bundle asynchronously and
  the temperature-profile block delivers its codes on pclk.
*/
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ps
module ccs_sequencer #(
  parameter int TICK_CYCLES    = ccs_pkg::TICK_CYC,
  parameter int DET_TICKS      = ccs_pkg::DETECT_TICKS,
  parameter int OS_TICKS       = ccs_pkg::OPEN_SHORT_TICKS,
  parameter int RETRY_TICKS    = ccs_pkg::RETRY_TICKS,
  parameter int PROFILE_CYCLES = ccs_pkg::PROFILE_CYC
) (
  input  wire logic               pclk,         // system clock
  input  wire logic               presetn,      // async reset
  input  wire logic               psel,         // apb select
  input  wire logic               penable,      // apb access phase
  input  wire logic               pwrite,       // apb direction
  input  wire logic [7:0]         paddr,        // apb byte address
  input  wire logic [31:0]        pwdata,       // apb write data
  output logic      [31:0]        prdata,       // apb read data
  output logic                    pready,       // apb ready
  output logic                    pslverr,      // unmapped address
  input  wire ccs_pkg::ccs_sense_s sense_in,    // analog comparator bundle
  input  wire logic [4:0]         prof_icode,   // profile current code
  input  wire logic [4:0]         prof_vcode,   // profile voltage code
  output ccs_pkg::ccs_drive_s     drive_out,    // power stage controls
  output logic      [11:0]        vreg_target,  // cv target, 12.5 mV units
  output logic      [5:0]         isense_mv,    // cc sense target, mV
  output logic      [3:0]         cell_count,   // decoded cells, 0 = error
  output logic                    alert_n       // shared alert, active low
);
  import ccs_pkg::*;

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function automatic logic [3:0] cells_of(input logic [1:0] hi, input logic [1:0] lo);
    int n;
    n = 1 + 3 * (2 - int'(hi)) + (2 - int'(lo));
    if (hi > LV_HIGH || lo > LV_HIGH || n > 8)
      return 4'h0;
    return 4'(n);
  endfunction : cells_of

  function automatic logic reg_hit(input logic [7:0] a);
    return a == ADR_CTRL || a == ADR_USER || a == ADR_THERM || a == ADR_ALERT_EN
        || a == ADR_ALERT || a == ADR_STATUS || a == ADR_DAC;
  endfunction : reg_hit

  ccs_sense_s sync1_r, sense;
  ccs_state_e state_r, state_nxt;
  logic [13:0] cyc_r;
  logic [16:0] tcnt_r;
  logic [18:0] prof_r;
  logic        tick, cell_err, unst_r, switching, wr, therm_act_r;
  logic        profile_en_r;
  logic [4:0]  user_i_r, user_v_r, ramp_r, target, cap, idac_r, vdac_r;
  logic [7:0]  t_start_r, t_end_r;
  logic [3:0]  al_en_r, al_r, al_evt;

  // --------------------------------------------------------------------
  // synchronisers: pins pass two flops before use
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_r <= '0;
      sense   <= '0;
    end
    else
    begin
      sync1_r <= sense_in;
      sense   <= sync1_r;
    end
  end

  // strap decode, a zero count is the ground/ground error or level code 3 on either strap
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cell_count <= 4'h0;
    else
      cell_count <= cells_of(sense.count_strap_hi, sense.count_strap_lo);
  end
  assign cell_err = cell_count == 4'h0;

  // --------------------------------------------------------------------
  // apb slave: zero wait, read data captured in the setup cycle
  // --------------------------------------------------------------------
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !reg_hit(paddr);
  assign wr      = psel && penable && pwrite && reg_hit(paddr);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        ADR_CTRL:     prdata <= {31'h0000_0000, profile_en_r};
        ADR_USER:     prdata <= {19'h0_0000, user_v_r, 3'h0, user_i_r};
        ADR_THERM:    prdata <= {16'h0000, t_end_r, t_start_r};
        ADR_ALERT_EN: prdata <= {28'h000_0000, al_en_r};
        ADR_ALERT:    prdata <= {28'h000_0000, al_r};
        ADR_STATUS:   prdata <= {14'h0000, state_r, 2'h0, therm_act_r, cell_err, cell_count};
        ADR_DAC:      prdata <= {19'h0_0000, vdac_r, 3'h0, idac_r};
        default:      prdata <= 32'h0000_0000;
      endcase
    end
  end

  // control registers; a profile refresh lands unless the host writes the user register that cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      profile_en_r <= 1'b1;
      user_i_r     <= RST_ICODE;
      user_v_r     <= RST_VCODE;
      t_start_r    <= RST_T_START;
      t_end_r      <= RST_T_END;
      al_en_r      <= 4'h0;
    end
    else
    begin
      if (wr && paddr == ADR_CTRL)
        profile_en_r <= pwdata[0];
      if (wr && paddr == ADR_USER)
      begin
        user_i_r <= pwdata[4:0];
        user_v_r <= pwdata[12:8];
      end
      else if (profile_en_r && prof_r == 19'(PROFILE_CYCLES - 1))
      begin
        user_i_r <= prof_icode;
        user_v_r <= prof_vcode;
      end
      if (wr && paddr == ADR_THERM)
      begin
        t_start_r <= pwdata[7:0];
        t_end_r   <= pwdata[15:8];
      end
      if (wr && paddr == ADR_ALERT_EN)
        al_en_r <= pwdata[3:0];
    end
  end

  // 11 ms profile refresh counter, free running
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prof_r <= 19'h0_0000;
    else if (prof_r == 19'(PROFILE_CYCLES - 1))
      prof_r <= 19'h0_0000;
    else
      prof_r <= prof_r + 19'h0_0001;
  end

  // --------------------------------------------------------------------
  // prescaler: both counters restart whenever the state changes
  // --------------------------------------------------------------------
  assign tick = cyc_r == 14'(TICK_CYCLES - 1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cyc_r  <= 14'h0000;
      tcnt_r <= 17'h0_0000;
    end
    else if (state_nxt != state_r)
    begin
      cyc_r  <= 14'h0000;
      tcnt_r <= 17'h0_0000;
    end
    else if (tick)
    begin
      cyc_r  <= 14'h0000;
      tcnt_r <= tcnt_r + 17'h0_0001;
    end
    else
      cyc_r <= cyc_r + 14'h0001;
  end

  // --------------------------------------------------------------------
  // charge cycle state machine
  // --------------------------------------------------------------------
  function automatic ccs_state_e phase_of(input logic low, input logic prech);
    if (low)
      return ST_TRICKLE;
    if (prech)
      return ST_PRECHG;
    return ST_MAIN;
  endfunction : phase_of

  always_comb
  begin
    state_nxt = state_r;
    if (cell_err)
      state_nxt = ST_CFG_ERR;
    else if (sense.therm_open)
      state_nxt = ST_MISSING; // no retry while the thermistor stays open
    else
    begin
      case (state_r)
        ST_CFG_ERR:
          state_nxt = ST_DET_LOAD;
        ST_DET_LOAD:
          if (tick && tcnt_r == 17'(DET_TICKS - 1))
            state_nxt = ST_DET_CHG;
        ST_DET_CHG:
          if (tick && tcnt_r == 17'(DET_TICKS - 1))
            state_nxt = (unst_r || sense.bat_unstable) ? ST_OPEN_SHT
                      : phase_of(sense.sense_low, sense.sense_prech);
        ST_OPEN_SHT:
          if (tick && tcnt_r == 17'(OS_TICKS - 1))
          begin
            if (sense.bat_open)
              state_nxt = ST_MISSING;
            else if (sense.bat_short)
              state_nxt = ST_SHORTED;
            else if (sense.bat_unstable)
              state_nxt = ST_DET_FAIL;
            else
              state_nxt = phase_of(sense.sense_low, sense.sense_prech);
          end
        ST_MISSING, ST_SHORTED, ST_DET_FAIL:
          if (tick && tcnt_r == 17'(RETRY_TICKS - 1))
            state_nxt = ST_DET_LOAD;
        ST_TRICKLE:
          if (!sense.sense_low)
            state_nxt = phase_of(1'b0, sense.sense_prech);
        ST_PRECHG:
          if (!sense.sense_prech)
            state_nxt = ST_MAIN;
        ST_MAIN:
          state_nxt = ST_MAIN;
        default:
          state_nxt = ST_CFG_ERR;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= ST_CFG_ERR;
    else
      state_r <= state_nxt;
  end

  // instability seen anywhere in the presence test decides the open/short test
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      unst_r <= 1'b0;
    else if (state_r != ST_DET_LOAD && state_r != ST_DET_CHG)
      unst_r <= 1'b0;
    else if (sense.bat_unstable)
      unst_r <= 1'b1;
  end

  // --------------------------------------------------------------------
  // current ramp and thermal cap
  // --------------------------------------------------------------------
  assign switching = state_r == ST_DET_CHG || state_r == ST_OPEN_SHT
                  || state_r == ST_PRECHG || state_r == ST_MAIN;

  // minimum code during detection, code 3 in precharge
  always_comb
  begin
    case (state_r)
      ST_PRECHG: target = CODE_PRECH;
      ST_MAIN:   target = profile_en_r ? prof_icode : user_i_r;
      default:   target = 5'h00;
    endcase
  end

  // ramp restarts from zero whenever the switcher is off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ramp_r <= 5'h00;
    else if (!switching)
      ramp_r <= 5'h00;
    else if (tick && ramp_r < target)
      ramp_r <= ramp_r + 5'h01;
    else if (tick && ramp_r > target)
      ramp_r <= ramp_r - 5'h01;
  end

  // linear cap; a combinational divide is fine at this clock rate
  always_comb
  begin
    logic [12:0] prod;
    prod = 13'(sense.die_temp - t_start_r) * 13'(CODE_MAX);
    if (sense.die_temp <= t_start_r)
      cap = CODE_MAX;
    else if (sense.die_temp >= t_end_r)
      cap = 5'h00;
    else
      cap = CODE_MAX - 5'(prod / 13'(t_end_r - t_start_r));
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idac_r      <= 5'h00;
      therm_act_r <= 1'b0;
    end
    else
    begin
      idac_r      <= (cap < ramp_r) ? cap : ramp_r;
      therm_act_r <= switching && cap < ramp_r;
    end
  end

  // --------------------------------------------------------------------
  // alerts: set wins over a clearing write; clearing the enable hides it
  // --------------------------------------------------------------------
  assign al_evt[AL_MISSING] = state_nxt == ST_MISSING && state_r != ST_MISSING;
  assign al_evt[AL_SHORT]   = state_nxt == ST_SHORTED && state_r != ST_SHORTED;
  assign al_evt[AL_DETFAIL] = state_nxt == ST_DET_FAIL && state_r != ST_DET_FAIL;
  assign al_evt[AL_THERMAL] = therm_act_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      al_r <= 4'h0;
    else
      al_r <= ((wr && paddr == ADR_ALERT) ? (al_r & pwdata[3:0]) : al_r)
            | (al_evt & al_en_r);
  end
  assign alert_n = ~|(al_r & al_en_r);

  // --------------------------------------------------------------------
  // drive outputs
  // --------------------------------------------------------------------
  assign drive_out.det_load_en = state_r == ST_DET_LOAD;
  assign drive_out.det_chg_en  = state_r == ST_DET_CHG;
  assign drive_out.trickle_en  = state_r == ST_TRICKLE;
  assign drive_out.switcher_en = switching;
  assign drive_out.icharge_dac = idac_r;
  assign drive_out.vcharge_dac = vdac_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vdac_r                <= 5'h00;
      vreg_target           <= 12'h000;
      isense_mv             <= 6'h00;
    end
    else
    begin
      vdac_r      <= profile_en_r ? prof_vcode : user_v_r;
      // widen before the product: eight cells at code 31 need all 12 bits
      vreg_target <= (12'(VREG_BASE) + 12'(vdac_r)) * 12'(cell_count);
      isense_mv   <= 6'(idac_r) + 6'h01;
    end
  end

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_strap_mid: assert property (sense.count_strap_hi == LV_MID && sense.count_strap_lo == LV_MID
    |=> cell_count == 4'h5) else $error("mid/mid strap not decoded as five");
  a_cfg_block: assert property (cell_err |=> state_r == ST_CFG_ERR ##0 !switching)
    else $error("charging with strap error");
  a_count_read: assert property (psel && !penable && !pwrite && paddr == ADR_STATUS
    |=> prdata[3:0] == $past(cell_count)) else $error("status cell count wrong");
  a_detect_len: assert property ($rose(state_r == ST_DET_CHG) |-> $past(tcnt_r) == 17'(DET_TICKS - 1))
    else $error("load phase length wrong");
  a_fault_block: assert property (state_r inside {ST_MISSING, ST_SHORTED, ST_DET_FAIL}
    |-> !switching && !drive_out.trickle_en) else $error("charging in fault");
  a_therm_open: assert property (sense.therm_open && !cell_err |=> state_r == ST_MISSING)
    else $error("open thermistor not missing");
  a_fault_alert: assert property (al_evt[AL_SHORT] && al_en_r[AL_SHORT] |=> !alert_n)
    else $error("short fault alert not raised");
  a_retry_go: assert property (state_r == ST_DET_FAIL && tick && tcnt_r == 17'(RETRY_TICKS - 1)
    && !cell_err && !sense.therm_open |=> state_r == ST_DET_LOAD) else $error("no retry");
  a_ramp_hold: assert property (switching && $past(switching) && !$past(tick) |-> $stable(ramp_r))
    else $error("ramp moved between ticks");
  a_cap_min: assert property (idac_r <= $past(cap) && idac_r <= $past(ramp_r))
    else $error("current code above cap or ramp");
  a_state_restart: assert property (state_r != $past(state_r) |-> cyc_r == 14'h0000 && tcnt_r == 17'h0_0000)
    else $error("prescaler not restarted");

  c_main: cover property (state_r == ST_PRECHG ##1 state_r == ST_MAIN);
  c_retry: cover property (state_r == ST_MISSING ##1 state_r == ST_DET_LOAD);
  c_thermal: cover property (therm_act_r && !alert_n);
  c_cfg_err: cover property (state_r == ST_CFG_ERR && cell_err);

endmodule : ccs_sequencer

// >>> ccs_sequencer_bench.sv
/*
  self-checking bench for the charge cycle sequencer over apb.
  assumes shortened tick and retry counts, zero wait apb slave.
*/
`timescale 1ns/1ps
module ccs_sequencer_bench;
  import ccs_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, topen = 0, alert_n, serr;
  logic [7:0]  paddr = 0, temp = 8'h19;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0]  strap = 0, cell_count;
  logic [2:0]  flt = 0;
  logic [4:0]  picode = 5, pvcode = 7, last_dac;
  logic [11:0] vreg;
  logic [5:0]  isense;
  ccs_sense_s  sense;
  ccs_drive_s  drive;
  int          miscompares = 0, n_checks = 0, gap = 0;
  bit          mon = 0;
  always #12.5 pclk = ~pclk;

  ccs_sequencer #(.TICK_CYCLES(4), .DET_TICKS(3), .OS_TICKS(3), .RETRY_TICKS(5), .PROFILE_CYCLES(20)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense_in(sense),
    .prof_icode(picode), .prof_vcode(pvcode), .drive_out(drive), .vreg_target(vreg),
    .isense_mv(isense), .cell_count(cell_count), .alert_n(alert_n));
  ccs_battery_model bat (.pclk(pclk), .presetn(presetn), .drive(drive), .strap(strap), .flt(flt),
    .topen(topen), .temp(temp), .sense(sense));

  task close_out;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out

  task chk(input logic [31:0] got, input logic [31:0] exp, input string w);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen at an edge
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : xfer

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1, a, d);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] e, input string w);
    xfer(0, a, 0);
    chk(rd, e, w);
  endtask : rdc

  // poll the state field, bounded so a stuck sequencer shows as a mismatch
  task wait_st(input logic [9:0] s);
    for (int i = 0; i < 300; i++)
    begin
      xfer(0, ADR_STATUS, 0);
      if (rd[17:8] === s)
        break;
    end
    chk(rd[17:8], s, "state");
  endtask : wait_st

  // applied current code may only step by one, at most once a tick
  always @(posedge pclk)
  begin
    if (mon && drive.icharge_dac !== last_dac)
    begin
      if (gap < 3 || (5'(drive.icharge_dac - last_dac) != 5'h01 && 5'(last_dac - drive.icharge_dac) != 5'h01))
        chk(drive.icharge_dac, last_dac, "ramp step");
      gap = 0;
    end
    else
      gap++;
    last_dac = drive.icharge_dac;
  end

  initial
  begin
    #400us;
    miscompares++;
    close_out();
  end

  initial
  begin
    int e;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    rdc(ADR_CTRL, 32'h0000_0001, "ctrl");
    rdc(ADR_USER, 32'h0000_1f1f, "user");
    rdc(ADR_THERM, 32'h0000_7d78, "therm");
    rdc(ADR_ALERT_EN, 32'h0000_0000, "alert_en");
    rdc(ADR_STATUS, 32'h0000_0110, "cfg err");
    xfer(0, 8'h1c, 0);
    chk(serr, 1'b1, "unmapped");
    $display("test reset done");
    for (int k = 0; k < 9; k++)
    begin
      strap <= {2'(k / 3), 2'(k % 3)};
      e = k == 0 ? 0 : (2 - k / 3) * 3 + 3 - k % 3;
      repeat (5) @(posedge pclk);
      chk(cell_count, e, "cells");
      xfer(0, ADR_STATUS, 0);
      chk(rd[3:0], e, "status cells");
    end
    $display("test straps done");
    strap <= 4'h9;
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    wait_st(10'h002);
    wait_st(10'h004);
    wait_st(10'h080);
    wait_st(10'h100);
    repeat (30) @(posedge pclk);
    chk(drive.icharge_dac, 3, "prech dac");
    wait_st(10'h200);
    repeat (40) @(posedge pclk);
    mon = 1;
    chk(drive.icharge_dac, 5, "ramp");
    chk(isense, 6, "isense");
    chk(vreg, 624, "vreg");
    wr(ADR_USER, 32'h0000_0409);
    repeat (30) @(posedge pclk);
    rdc(ADR_USER, 32'h0000_0705, "overwrite");
    picode <= 2;
    repeat (30) @(posedge pclk);
    chk(drive.icharge_dac, 2, "ramp down");
    wr(ADR_CTRL, 0);
    wr(ADR_USER, 32'h0000_0409);
    repeat (40) @(posedge pclk);
    chk(drive.icharge_dac, 9, "user dac");
    chk(vreg, 618, "user vreg");
    $display("test charge done");
    wr(ADR_ALERT_EN, 8);
    temp <= 122;
    wr(ADR_USER, 32'h0000_041f);
    repeat (80) @(posedge pclk);
    chk(drive.icharge_dac, 19, "cap");
    xfer(0, ADR_STATUS, 0);
    chk(rd[5], 1, "therm active");
    chk(alert_n, 0, "therm alert");
    wr(ADR_USER, 32'h0000_0409);
    repeat (120) @(posedge pclk);
    temp <= 25;
    repeat (5) @(posedge pclk);
    wr(ADR_ALERT, 0);
    @(posedge pclk);
    chk(alert_n, 1, "alert clear");
    $display("test thermal done");
    mon = 0;
    wr(ADR_ALERT_EN, 7);
    topen <= 1;
    wait_st(10'h010);
    chk(alert_n, 0, "missing alert");
    chk(drive.switcher_en, 0, "blocked");
    topen <= 0;
    for (int f = 0; f < 3; f++)
    begin
      flt <= f == 0 ? 3'h5 : f == 1 ? 3'h3 : 3'h1;
      wait_st(10'h008);
      wr(ADR_ALERT, 0);
      wait_st(10'(10'h010 << f));
      xfer(0, ADR_ALERT, 0);
      chk(rd, 1 << f, "fault alert");
    end
    $display("test faults done");
    close_out();
  end
endmodule : ccs_sequencer_bench
